// ===== src/nco_phase_modulator_sine.sv
// Direct digital synthesizer core with AHB-Lite register slave
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module nco_phase_modulator_sine
  import nco_pkg::*;
#(
  parameter int ACC_WIDTH = ACC_W
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              phase_reset,
  input  wire logic              power_down,
  input  wire logic              tuning_select_input,
  input  wire logic              offset_select_input,
  input  wire logic              comparator_in,
  output logic      [AMP_W-1:0]  converter_data,
  output logic                   converter_enable,
  output logic                   sign_out,
  output logic                   sign_out_en
);
  // Pin inputs pass a synchroniser first
  logic [4:0] pinsRaw;
  logic [4:0] pinsSync;
  assign pinsRaw = {comparator_in, offset_select_input, tuning_select_input,
                    power_down, phase_reset};
  sync2 #(.W(5)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (pinsRaw),
    .dout    (pinsSync)
  );
  logic phaseRst, pdPin, tselPin, oselPin, cmpIn;
  assign {cmpIn, oselPin, tselPin, pdPin, phaseRst} = pinsSync;

  // Software registers
  logic [ACC_W-1:0]   tuning_word_a_r, tuning_word_a_nxt;
  logic [ACC_W-1:0]   tuning_word_b_r, tuning_word_b_nxt;
  logic [PHASE_W-1:0] offsetA_r, offsetA_nxt;
  logic [PHASE_W-1:0] offsetB_r, offsetB_nxt;
  logic [CTRL_W-1:0]  ctrl_r, ctrl_nxt;
  // Bus data phase state
  logic               wrPend_r, wrPend_nxt;
  logic [7:0]         addr_r, addr_nxt;
  logic [31:0]        hrdata_r, hrdata_nxt;
  logic               accValid;

  assign accValid = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Datapath state
  logic [ACC_W-1:0]   acc_r, acc_nxt;
  logic [PHASE_W-1:0] phase_r, phase_nxt;
  logic [AMP_W-1:0]   conv_r, conv_nxt;
  logic               convEn_r, convEn_nxt;
  logic               sign_r, sign_nxt;
  logic               signEn_r, signEn_nxt;
  logic               tuning_select_bit;
  logic               offSel;
  logic               logic_output_enable;
  logic               logic_output_source;
  logic               converter_power_down_bit;
  logic [ACC_W-1:0]   incr;
  logic [PHASE_W-1:0] offs;

  phase_bus_if pb ();
  sine_rom u_rom (
    .clk     (clk),
    .reset_n (reset_n),
    .pb      (pb.rom)
  );

  always_comb begin
    tuning_word_a_nxt = tuning_word_a_r;
    tuning_word_b_nxt = tuning_word_b_r;
    offsetA_nxt       = offsetA_r;
    offsetB_nxt       = offsetB_r;
    ctrl_nxt          = ctrl_r;
    wrPend_nxt        = 1'b0;
    addr_nxt          = addr_r;
    hrdata_nxt        = hrdata_r;
    if (wrPend_r) begin
      case (addr_r)
        TUNE_A_ADDR: tuning_word_a_nxt = hwdata[ACC_W-1:0];
        TUNE_B_ADDR: tuning_word_b_nxt = hwdata[ACC_W-1:0];
        OFFS_A_ADDR: offsetA_nxt = hwdata[PHASE_W-1:0];
        OFFS_B_ADDR: offsetB_nxt = hwdata[PHASE_W-1:0];
        CTRL_ADDR:   ctrl_nxt = hwdata[CTRL_W-1:0];
        default: ;
      endcase
    end
    if (accValid) begin
      addr_nxt   = {haddr[7:2], 2'b00};
      wrPend_nxt = hwrite && (haddr[31:8] == 24'h000000);
      if (!hwrite) begin
        case ({haddr[7:2], 2'b00})
          TUNE_A_ADDR: hrdata_nxt = {4'h0, tuning_word_a_nxt};
          TUNE_B_ADDR: hrdata_nxt = {4'h0, tuning_word_b_nxt};
          OFFS_A_ADDR: hrdata_nxt = {20'h00000, offsetA_nxt};
          OFFS_B_ADDR: hrdata_nxt = {20'h00000, offsetB_nxt};
          CTRL_ADDR:   hrdata_nxt = {25'h0000000, ctrl_nxt};
          STATUS_ADDR: hrdata_nxt = {20'h00000, phase_r};
          default:     hrdata_nxt = 32'h00000000;
        endcase
        if (haddr[31:8] != 24'h000000) begin
          hrdata_nxt = 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tuning_word_a_r <= '0;
      tuning_word_b_r <= '0;
      offsetA_r       <= '0;
      offsetB_r       <= '0;
      ctrl_r          <= CTRL_RESET;
      wrPend_r        <= 1'b0;
      addr_r          <= 8'h00;
      hrdata_r        <= 32'h00000000;
    end else begin
      tuning_word_a_r <= tuning_word_a_nxt;
      tuning_word_b_r <= tuning_word_b_nxt;
      offsetA_r       <= offsetA_nxt;
      offsetB_r       <= offsetB_nxt;
      ctrl_r          <= ctrl_nxt;
      wrPend_r        <= wrPend_nxt;
      addr_r          <= addr_nxt;
      hrdata_r        <= hrdata_nxt;
    end
  end

  assign tuning_select_bit        = ctrl_r[CTRL_TUNE_SEL];
  assign logic_output_enable      = ctrl_r[CTRL_OUT_EN];
  assign logic_output_source      = ctrl_r[CTRL_OUT_SRC];
  assign converter_power_down_bit = ctrl_r[CTRL_CONV_PD];

  always_comb begin
    incr = (ctrl_r[CTRL_PIN_SW] ? tselPin : tuning_select_bit) ? tuning_word_b_r
                                                               : tuning_word_a_r;
    offSel = ctrl_r[CTRL_PIN_SW] ? oselPin : ctrl_r[CTRL_OFFS_SEL];
    offs   = offSel ? offsetB_r : offsetA_r;
    acc_nxt = acc_r + incr;
    phase_nxt = acc_r[ACC_W-1 -: PHASE_W] + offs;
    if (phaseRst) begin
      acc_nxt   = '0;
      phase_nxt = '0;
    end
    convEn_nxt = !(pdPin || converter_power_down_bit);
    if (!convEn_nxt) begin
      conv_nxt = AMP_MID;
    end else if (ctrl_r[CTRL_MODE] && !logic_output_enable) begin
      // Triangle bypasses the table; fold the phase
      conv_nxt = phase_r[PHASE_W-1] ? ~phase_r[PHASE_W-2 -: AMP_W] : phase_r[PHASE_W-2 -: AMP_W];
    end else begin
      conv_nxt = pb.amp;
    end
    signEn_nxt = logic_output_enable;
    sign_nxt   = logic_output_enable && (logic_output_source ? cmpIn : phase_r[PHASE_W-1]);
  end

  assign pb.phase = phase_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r    <= '0;
      phase_r  <= '0;
      conv_r   <= AMP_MID;
      convEn_r <= 1'b0;
      sign_r   <= 1'b0;
      signEn_r <= 1'b0;
    end else begin
      acc_r    <= acc_nxt;
      phase_r  <= phase_nxt;
      conv_r   <= conv_nxt;
      convEn_r <= convEn_nxt;
      sign_r   <= sign_nxt;
      signEn_r <= signEn_nxt;
    end
  end

  // Zero-wait OKAY slave keeps the bus simple
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = hrdata_r;
  assign converter_data   = conv_r;
  assign converter_enable = convEn_r;
  assign sign_out         = sign_r;
  assign sign_out_en      = signEn_r;
endmodule // nco_phase_modulator_sine

// ===== src/nco_pkg.sv
// Shared constants for the phase modulator and sine core
package nco_pkg;
  localparam int ACC_W      = 28;
  localparam int PHASE_W    = 12;
  localparam int AMP_W      = 10;
  localparam int QTR_W      = PHASE_W - 2;
  localparam int DATA_W     = 32;

  // Register byte addresses
  localparam logic [7:0] TUNE_A_ADDR   = 8'h00;
  localparam logic [7:0] TUNE_B_ADDR   = 8'h04;
  localparam logic [7:0] OFFS_A_ADDR   = 8'h08;
  localparam logic [7:0] OFFS_B_ADDR   = 8'h0c;
  localparam logic [7:0] CTRL_ADDR     = 8'h10;
  localparam logic [7:0] STATUS_ADDR   = 8'h14;

  // Control field positions
  localparam int CTRL_TUNE_SEL   = 0;
  localparam int CTRL_OFFS_SEL   = 1;
  localparam int CTRL_PIN_SW     = 2;
  localparam int CTRL_MODE       = 3;
  localparam int CTRL_OUT_EN     = 4;
  localparam int CTRL_OUT_SRC    = 5;
  localparam int CTRL_CONV_PD    = 6;
  localparam int CTRL_W          = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  localparam logic [AMP_W-1:0] AMP_MID = 10'h200;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

// ===== src/phase_bus_if.sv
// Phase word carried from the accumulator to the sine table
`timescale 1ns/1ps
interface phase_bus_if;
  logic [nco_pkg::PHASE_W-1:0] phase;
  logic [nco_pkg::AMP_W-1:0]   amp;
  modport src (output phase, input amp);
  modport rom (input phase, output amp);
endinterface

// ===== src/sine_rom.sv
// Quarter-wave sine lookup with registered amplitude output
`timescale 1ns/1ps
module sine_rom
  import nco_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  phase_bus_if.rom pb
);
  logic [AMP_W-2:0] table_q [0:(1<<QTR_W)-1];
  logic [AMP_W-1:0] amp_r;
  logic [AMP_W-1:0] amp_nxt;
  logic [QTR_W-1:0] idx;
  logic [AMP_W-2:0] mag;

  // Table filled by a constant sine expression in an initial block at time zero
  initial begin
    for (int i = 0; i < (1 << QTR_W); i++) begin
      table_q[i] = (AMP_W-1)'($rtoi(511.0 * $sin(3.14159265358979 * (real'(i) + 0.5)
                   / real'(2 << QTR_W))));
    end
  end

  always_comb begin
    idx = pb.phase[PHASE_W-2] ? ~pb.phase[QTR_W-1:0] : pb.phase[QTR_W-1:0];
    mag = table_q[idx];
    amp_nxt = pb.phase[PHASE_W-1] ? (AMP_MID - {1'b0, mag}) : (AMP_MID + {1'b0, mag});
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      amp_r <= AMP_MID;
    end else begin
      amp_r <= amp_nxt;
    end
  end

  assign pb.amp = amp_r;
endmodule // sine_rom

// ===== src/sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] out_nxt;

  always_comb begin
    meta_nxt = din;
    out_nxt  = meta_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout   <= out_nxt;
    end
  end
endmodule // sync2

// ===== tb/nco_phase_modulator_sine_sva.sv
// Port checker for the synthesizer core
`timescale 1ns/1ps
module nco_phase_modulator_sine_sva
  import nco_pkg::*;
(
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic             phase_reset,
  input wire logic             power_down,
  input wire logic [AMP_W-1:0] converter_data,
  input wire logic             converter_enable,
  input wire logic             sign_out,
  input wire logic             sign_out_en
);
  logic       take;
  logic [3:0] wrHist_r;
  logic [3:0] wrHist_nxt;
  assign take = hsel && hready && htrans == HTRANS_NONSEQ;
  // Pin enable may only move a few cycles after a register write
  always_comb wrHist_nxt = {wrHist_r[2:0], take && hwrite};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) wrHist_r <= 4'h0;
    else wrHist_r <= wrHist_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence prstHeld; phase_reset[*8]; endsequence
  sequence statusRd; take && !hwrite && haddr == {24'h0, STATUS_ADDR}; endsequence
  pin_gate_a: assert property (!sign_out_en |-> !sign_out)
    else $error("logic pin high while not driven");
  pin_cause_a: assert property ($changed(sign_out_en) |-> |wrHist_r)
    else $error("logic pin enable moved without a write");
  pd_off_a: assert property (power_down[*4] |-> !converter_enable)
    else $error("converter still on during power down");
  pd_mid_a: assert property (power_down[*6] |-> converter_data == AMP_MID)
    else $error("converter data not midscale in power down");
  pd_wake_a: assert property ($rose(converter_enable) |-> !$past(power_down, 2))
    else $error("converter woke while power down high");
  prst_mid_a: assert property (prstHeld |-> converter_data == AMP_MID)
    else $error("amplitude not midscale while phase held");
  prst_status_a: assert property (prstHeld ##0 statusRd |=> hrdata == 32'h0)
    else $error("phase not zero while phase held");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
endmodule // nco_phase_modulator_sine_sva
bind nco_phase_modulator_sine nco_phase_modulator_sine_sva u_nco_phase_modulator_sine_sva (
  .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .phase_reset, .power_down, .converter_data, .converter_enable, .sign_out, .sign_out_en);

// ===== tb/nco_phase_modulator_sine_test.sv
// Self-checking bench for the synthesizer core
`timescale 1ns/1ps
module nco_phase_modulator_sine_test;
  import nco_pkg::*;
  logic             clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic             phase_reset, power_down, comparator_in;
  logic             tuning_select_input, offset_select_input;
  logic             converter_enable, sign_out, sign_out_en;
  logic [1:0]       htrans;
  logic [31:0]      haddr, hwdata, hrdata, q, s1;
  logic [AMP_W-1:0] converter_data;
  logic [6:0]       ct [4] = '{7'h00, 7'h01, 7'h04, 7'h05};
  logic             pn [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  int               n_errors, checks;

  nco_phase_modulator_sine u_nco_phase_modulator_sine (
    .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(HSIZE_WORD), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .phase_reset, .power_down,
    .tuning_select_input, .offset_select_input, .comparator_in, .converter_data,
    .converter_enable, .sign_out, .sign_out_en);

  always #4 clk = ~clk;

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // Two status reads are two clocks apart, so phase moves by two increments
  task automatic step(input logic [11:0] e);
    bus(1'b0, STATUS_ADDR, 32'h0);
    s1 = q;
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk("phase_step", {20'h0, e}, (q - s1) & 32'hfff);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwdata = 32'h0;
    phase_reset = 1'b0;
    power_down = 1'b0;
    comparator_in = 1'b0;
    tuning_select_input = 1'b0;
    offset_select_input = 1'b0;
    n_errors = 0;
    checks = 0;
    idle(20);
    chk("reset_amp", AMP_MID, converter_data);
    reset_n <= 1'b1;
    idle(1);
    wr(TUNE_A_ADDR, 32'h0030000);
    rd(TUNE_A_ADDR, 32'h0030000, "tune_a");
    rd(8'h18, 32'h0, "unmapped");
    step(12'h006);
    // Increment of all ones in the top field must wrap backwards
    wr(TUNE_A_ADDR, 32'hfff0000);
    // Old increment still lands one edge after the write; keep it out of the window
    idle(2);
    step(12'hffe);
    wr(TUNE_A_ADDR, 32'h0);
    wr(TUNE_B_ADDR, 32'h0050000);
    for (int i = 0; i < 4; i++) begin
      tuning_select_input <= pn[i];
      wr(CTRL_ADDR, {25'h0, ct[i]});
      idle(4);
      step((i == 1 || i == 2) ? 12'h00a : 12'h000);
    end
    phase_reset <= 1'b1;
    idle(8);
    rd(STATUS_ADDR, 32'h0, "held_phase");
    rd(TUNE_B_ADDR, 32'h0050000, "kept_tune_b");
    phase_reset <= 1'b0;
    wr(OFFS_A_ADDR, 32'h123);
    wr(OFFS_B_ADDR, 32'h456);
    for (int i = 0; i < 4; i++) begin
      offset_select_input <= pn[i];
      wr(CTRL_ADDR, {29'h0, ct[i][2], ct[i][0], 1'b0});
      idle(4);
      rd(STATUS_ADDR, (i == 1 || i == 2) ? 32'h456 : 32'h123, "offset");
    end
    offset_select_input <= 1'b0;
    wr(CTRL_ADDR, 32'h18);
    wr(OFFS_A_ADDR, 32'h400);
    idle(6);
    chk("sine_peak", 1, converter_data > 10'h3f0);
    chk("msb_low", 2, {sign_out_en, sign_out});
    wr(OFFS_A_ADDR, 32'hc00);
    idle(6);
    chk("sine_trough", 1, converter_data < 10'h010);
    chk("msb_high", 3, {sign_out_en, sign_out});
    wr(OFFS_A_ADDR, 32'h0);
    idle(6);
    chk("sine_zero", AMP_MID, converter_data);
    // Mode bit with the logic pin off skips the table; just under half a cycle is the ramp top
    wr(CTRL_ADDR, 32'h08);
    wr(OFFS_A_ADDR, 32'h7fe);
    idle(6);
    chk("triangle_top", 32'h3ff, converter_data);
    wr(CTRL_ADDR, 32'h30);
    for (int c = 1; c >= 0; c--) begin
      comparator_in <= c[0];
      idle(5);
      chk("comp_route", c, sign_out);
    end
    wr(CTRL_ADDR, 32'h20);
    idle(4);
    chk("pin_off", 0, {sign_out_en, sign_out});
    power_down <= 1'b1;
    idle(8);
    chk("pd_pin", 0, converter_enable);
    chk("pd_amp", AMP_MID, converter_data);
    power_down <= 1'b0;
    idle(6);
    chk("pd_wake", 1, converter_enable);
    wr(CTRL_ADDR, 32'h40);
    idle(4);
    chk("pd_bit", 0, converter_enable);
    conclude();
  end

  // Whole run is a few hundred clocks; this margin only catches a hang
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule // nco_phase_modulator_sine_test
